// ===== rcms_pkg.sv
// Purpose: Shared constants and types for the reset control and mode select block.
// Assumes: One core clock; slower system clock rate is an enable tick from a divider.
// Notes: Reset line masks are indexed by the LINE_* positions.
package rcms_pkg;

  localparam int SYSTEM_CLOCK_OUT_DIV = 2;
  localparam int CNT_W = 4;

  localparam logic [CNT_W-1:0] HOLD_LAST = 4'h3;
  localparam logic [CNT_W-1:0] BUS_MON_TICKS = 4'h8;
  localparam logic [CNT_W-1:0] FIRST_CYCLE_TICKS = 4'hA;
  localparam logic [CNT_W-1:0] FIRST_CYCLE_LAST = FIRST_CYCLE_TICKS - 4'h1;

  localparam int LINE_EXT = 0;
  localparam int LINE_CLK = 1;
  localparam int LINE_MST = 2;
  localparam logic [2:0] MASK_NONE = 3'h0;
  localparam logic [2:0] MASK_EXT = 3'h1;
  localparam logic [2:0] MASK_ALL = 3'h7;
  localparam logic [2:0] MASK_TEST = 3'h5;

  localparam int CF_BOOT16 = 0;
  localparam int CF_ARB = 1;
  localparam int CF_FC = 2;
  localparam int CF_ADDR = 3;
  localparam int CF_PORTA = 8;
  localparam int CF_PORTB = 9;
  localparam int CF_TEST = 10;
  localparam int CF_SYNTH = 11;
  localparam int CF_BDM = 12;
  localparam int CFG_W = 13;
  localparam logic [CFG_W-1:0] CFG_RESET = 13'h0801;

  typedef enum logic [1:0] {ST_RUN, ST_SYNC_WAIT, ST_ASSERT, ST_RELEASE} rcms_state_t;

endpackage

// ===== rcms_reset_ctrl.sv
// Purpose: Reset source classification, reset line drive and reset-time strap capture.
// Assumes: All inputs are synchronous to core_clk except the external reset pin and the rst_b power-up reset.
// Notes: Strap inputs are active low; a high pin keeps the default pin function.
`timescale 1ns/10ps

module rcms_reset_ctrl
  import rcms_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ext_reset_in_b,
  input wire logic watchdog_timeout,
  input wire logic halt_fault,
  input wire logic ref_clock_loss,
  input wire logic test_reset_req,
  input wire logic reset_instr_exec,
  input wire logic bus_cycle_active,
  input wire logic bus_cycle_end,
  input wire logic bus_grant_out,
  input wire logic boot_width_strap,
  input wire logic arb_select_strap,
  input wire logic func_code_select_strap,
  input wire logic [4:0] addr_ext_strap,
  input wire logic bus_ctrl_port_strap,
  input wire logic irq_port_strap,
  input wire logic test_mode_strap,
  input wire logic clock_source_strap,
  input wire logic [1:0] breakpoint_request,
  output logic system_clock_out,
  output logic ext_reset_drive,
  output logic clock_module_reset,
  output logic master_reset,
  output logic instr_reset_flag,
  output logic bus_term_force,
  output logic first_bus_start,
  output logic boot_port_16bit,
  output logic arb_pins_alt,
  output logic fc_pins_alt,
  output logic [4:0] addr_cs_alt,
  output logic aux_io_port_a_sel,
  output logic aux_io_port_b_sel,
  output logic test_mode_en,
  output logic clk_src_synth,
  output logic bdm_enable,
  output logic ext_master_access
);

  rcms_state_t st_reg, st_next;
  logic [2:0] lines_reg, lines_next;
  logic [2:0] pend_reg, pend_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CFG_W-1:0] cfg_reg, cfg_next;
  logic instr_reg, instr_next;
  logic first_reg, first_next;
  logic sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic [1:0] div_reg, div_next;
  logic system_clock_out_reg, system_clock_out_next;
  logic tick, ext_req, async_hit, sync_hit;
  logic [2:0] sync_mask;

  // Low strap means alternate function, so each field except boot width, clock source, address and BDM is the inverted pin.
  function automatic logic [CFG_W-1:0] sample_straps();
    logic [CFG_W-1:0] v;
    v = '0;
    v[CF_BOOT16] = boot_width_strap;
    v[CF_ARB] = ~arb_select_strap;
    v[CF_FC] = ~func_code_select_strap;
    for (int j = 0; j < 5; j++) begin
      // Straps below position j are forced high so only j and above can convert it.
      v[CF_ADDR+j] = ~&(addr_ext_strap | ~(5'h1F << j));
    end
    v[CF_PORTA] = ~bus_ctrl_port_strap;
    v[CF_PORTB] = ~irq_port_strap;
    v[CF_TEST] = ~test_mode_strap;
    v[CF_SYNTH] = clock_source_strap;
    v[CF_BDM] = ~&breakpoint_request;
    return v;
  endfunction

  assign tick = (div_reg == 2'(SYSTEM_CLOCK_OUT_DIV - 1));
  assign ext_req = ~sync2_reg;
  assign async_hit = watchdog_timeout | halt_fault;
  assign sync_hit = ext_req | ref_clock_loss | test_reset_req;
  assign sync_mask = (ext_req | ref_clock_loss) ? MASK_ALL : MASK_TEST;
  assign bus_term_force = (st_reg == ST_SYNC_WAIT) && (cnt_reg == BUS_MON_TICKS);

  always_comb begin
    sync1_next = ext_reset_in_b;
    sync2_next = sync1_reg;
    div_next = tick ? 2'h0 : div_reg + 2'h1;
    system_clock_out_next = (div_next < 2'(SYSTEM_CLOCK_OUT_DIV / 2));
  end

  always_comb begin
    st_next = st_reg;
    lines_next = lines_reg;
    pend_next = pend_reg;
    cnt_next = cnt_reg;
    instr_next = instr_reg;
    first_next = 1'b0;
    cfg_next = cfg_reg;
    if (async_hit) begin
      // Catastrophic sources cannot wait for a bus cycle, so they cut in at once.
      st_next = ST_ASSERT;
      lines_next = lines_reg | MASK_ALL;
      cnt_next = '0;
    end else if (reset_instr_exec && st_reg == ST_RUN) begin
      st_next = ST_ASSERT;
      lines_next = MASK_EXT;
      instr_next = 1'b1;
      cnt_next = '0;
    end else if (tick) begin
      unique case (st_reg)
        ST_RUN: begin
          if (sync_hit) begin
            cnt_next = '0;
            if (bus_cycle_active && !bus_cycle_end) begin
              st_next = ST_SYNC_WAIT;
              pend_next = sync_mask;
            end else begin
              st_next = ST_ASSERT;
              lines_next = sync_mask;
            end
          end
        end
        ST_SYNC_WAIT: begin
          pend_next = sync_hit ? (pend_reg | sync_mask) : pend_reg;
          if (bus_cycle_end || bus_term_force) begin
            st_next = ST_ASSERT;
            lines_next = pend_next;
            cnt_next = '0;
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end
        ST_ASSERT: begin
          if (lines_reg[LINE_MST]) begin
            cfg_next = sample_straps();
          end
          if (sync_hit) begin
            lines_next = lines_reg | sync_mask;
            cnt_next = '0;
          end else if (cnt_reg == HOLD_LAST) begin
            st_next = ST_RELEASE;
            lines_next = MASK_NONE;
            instr_next = 1'b0;
            cnt_next = '0;
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end
        ST_RELEASE: begin
          if (sync_hit) begin
            st_next = ST_ASSERT;
            lines_next = sync_mask;
            cnt_next = '0;
          end else if (cnt_reg == FIRST_CYCLE_LAST) begin
            st_next = ST_RUN;
            first_next = 1'b1;
            cnt_next = '0;
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Power-up is treated as an asynchronous source asserting all three lines.
      st_reg <= ST_ASSERT;
      lines_reg <= MASK_ALL;
      pend_reg <= MASK_NONE;
      cnt_reg <= '0;
      cfg_reg <= CFG_RESET;
      instr_reg <= 1'b0;
      first_reg <= 1'b0;
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      div_reg <= 2'h0;
      system_clock_out_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      lines_reg <= lines_next;
      pend_reg <= pend_next;
      cnt_reg <= cnt_next;
      cfg_reg <= cfg_next;
      instr_reg <= instr_next;
      first_reg <= first_next;
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      div_reg <= div_next;
      system_clock_out_reg <= system_clock_out_next;
    end
  end

  assign system_clock_out = system_clock_out_reg;
  assign ext_reset_drive = lines_reg[LINE_EXT];
  assign clock_module_reset = lines_reg[LINE_CLK];
  assign master_reset = lines_reg[LINE_MST];
  assign instr_reset_flag = instr_reg;
  assign first_bus_start = first_reg;
  assign boot_port_16bit = cfg_reg[CF_BOOT16];
  assign arb_pins_alt = cfg_reg[CF_ARB];
  assign fc_pins_alt = cfg_reg[CF_FC];
  assign addr_cs_alt = cfg_reg[CF_ADDR +: 5];
  assign aux_io_port_a_sel = cfg_reg[CF_PORTA];
  assign aux_io_port_b_sel = cfg_reg[CF_PORTB];
  assign test_mode_en = cfg_reg[CF_TEST];
  assign clk_src_synth = cfg_reg[CF_SYNTH];
  assign bdm_enable = cfg_reg[CF_BDM];
  // Slave access is only meaningful with the factory mode latched at reset.
  assign ext_master_access = cfg_reg[CF_TEST] & bus_grant_out;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  AST_EXT_SYNC: assert property (
    (st_reg == ST_RUN && !master_reset && $fell(ext_reset_in_b) && !async_hit && !sync_hit)
      |=> !master_reset)
    else $error("External reset acted without synchronisation.");
  AST_ASYNC_NOW: assert property (
    async_hit |=> (master_reset && clock_module_reset && ext_reset_drive))
    else $error("Asynchronous reset not applied at once.");
  AST_SYNC_DEFER: assert property (
    (st_reg == ST_SYNC_WAIT) |-> !master_reset)
    else $error("Synchronous reset applied inside a bus cycle.");
  AST_BUS_MON: assert property (
    $rose(st_reg == ST_SYNC_WAIT) |-> ##[1:40] (bus_term_force || st_reg != ST_SYNC_WAIT))
    else $error("Bus monitor failed to end a stuck cycle.");
  AST_INSTR_ONLY_EXT: assert property (
    (st_reg == ST_RUN && reset_instr_exec && !async_hit)
      |=> (ext_reset_drive && instr_reset_flag && !master_reset && !clock_module_reset))
    else $error("Reset instruction drove the wrong lines.");
  AST_LINE_NEST: assert property (
    (clock_module_reset |-> master_reset) and (master_reset |-> ext_reset_drive))
    else $error("Reset line combination not allowed.");
  AST_CFG_HOLD: assert property (
    (st_reg != ST_ASSERT && $past(st_reg) != ST_ASSERT) |-> $stable(cfg_reg))
    else $error("Captured straps changed outside reset.");
  AST_FIRST_CYCLE: assert property (
    ($fell(ext_reset_drive) && !sync_hit) |-> !first_bus_start [*8] ##[10:14] first_bus_start)
    else $error("First bus cycle not ten ticks after release.");
  AST_SLAVE_ACCESS: assert property (
    ext_master_access |-> (test_mode_en && bus_grant_out))
    else $error("External master access outside slave mode.");
  AST_STRAP_LATCH: assert property (
    $fell(master_reset) |-> (test_mode_en == !$past(test_mode_strap)
      && clk_src_synth == $past(clock_source_strap)))
    else $error("Mode straps not latched at reset release.");

endmodule // rcms_reset_ctrl

// ===== rcms_strap_model.sv
// Purpose: External strap drivers and reset pin source facing the reset controller.
// Assumes: Data bus straps have weak pull-ups, so a released line reads high.
// Notes: The bench opens the strap drive window during reset and closes it after release.
`timescale 1ns/10ps
module rcms_strap_model (
  input wire logic drive_en,
  input wire logic [11:0] pattern,
  input wire logic ext_req,
  output logic ext_reset_in_b,
  output logic boot_width_strap,
  output logic arb_select_strap,
  output logic func_code_select_strap,
  output logic [4:0] addr_ext_strap,
  output logic bus_ctrl_port_strap,
  output logic irq_port_strap,
  output logic test_mode_strap,
  output logic clock_source_strap
);
  // A released line shows the pull-up level, never the last driven value.
  assign {clock_source_strap, test_mode_strap, irq_port_strap, bus_ctrl_port_strap,
    addr_ext_strap, func_code_select_strap, arb_select_strap,
    boot_width_strap} = drive_en ? pattern : 12'hFFF;
  assign ext_reset_in_b = !ext_req;
endmodule // rcms_strap_model

// ===== tb_reset_control_mode_select.sv
// Purpose: Self-checking bench for reset source handling and strap capture.
// Assumes: Tick is every second core cycle; hold and monitor counts from the package.
// Notes: Strap drive is dropped once the reset lines fall, before the first bus cycle.
`timescale 1ns/10ps
module tb_reset_control_mode_select;
  import rcms_pkg::*;
  localparam logic [11:0] P0 = 12'h2D6;
  localparam logic [11:0] P1 = 12'hD29;
  logic core_clk, rst_b, watchdog_timeout, halt_fault, ref_clock_loss, test_reset_req;
  logic reset_instr_exec, bus_cycle_active, bus_cycle_end, bus_grant_out, drive_en, ext_req;
  logic [11:0] pattern;
  logic [1:0] breakpoint_request;
  logic ext_reset_in_b, boot_width_strap, arb_select_strap, func_code_select_strap;
  logic bus_ctrl_port_strap, irq_port_strap, test_mode_strap, clock_source_strap;
  logic [4:0] addr_ext_strap, addr_cs_alt;
  logic system_clock_out, ext_reset_drive, clock_module_reset, master_reset, instr_reset_flag;
  logic bus_term_force, first_bus_start, boot_port_16bit, arb_pins_alt, fc_pins_alt;
  logic aux_io_port_a_sel, aux_io_port_b_sel, test_mode_en, clk_src_synth, bdm_enable;
  logic ext_master_access;
  logic [2:0] lines;
  int fails, cmp_count;
  assign lines = {master_reset, clock_module_reset, ext_reset_drive};
  rcms_reset_ctrl rcms_reset_ctrl_i (.*);
  rcms_strap_model rcms_strap_model_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cfg_check(input logic [11:0] p, input logic [1:0] bk);
    logic [4:0] ae;
    for (int j = 0; j < 5; j++) begin
      ae[j] = |(~p[7:3] & (5'h1F << j));
    end
    chk("boot16", boot_port_16bit, p[0]);
    chk("arb", arb_pins_alt, !p[1]);
    chk("fc", fc_pins_alt, !p[2]);
    chk("addr", addr_cs_alt, {3'h0, ae});
    for (int j = 0; j < 5; j++) begin
      chk("addr_bit", addr_cs_alt[j], |(~p[7:3] & (5'h1F << j)));
    end
    chk("port_a", aux_io_port_a_sel, !p[8]);
    chk("port_b", aux_io_port_b_sel, !p[9]);
    chk("test", test_mode_en, !p[10]);
    chk("synth", clk_src_synth, p[11]);
    chk("bdm", bdm_enable, !(&bk));
  endtask
  // Waits for the lines to fall, releases the straps and times the first bus cycle.
  task automatic finish_reset();
    int n;
    logic [11:0] p;
    p = pattern;
    n = 0;
    while (master_reset !== 1'b0 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("release", master_reset, 8'h00);
    @(posedge core_clk);
    drive_en <= 1'b0;
    n = 0;
    while (first_bus_start !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("first_cycle", 8'(n >= 18 && n <= 22), 8'h01);
    cfg_check(p, breakpoint_request);
    repeat (6) @(posedge core_clk);
    #1;
    cfg_check(p, breakpoint_request);
  endtask
  task automatic s_slave();
    logic c0;
    @(posedge core_clk);
    bus_grant_out <= 1'b1;
    #1;
    c0 = system_clock_out;
    chk("slave_on", ext_master_access, 8'h01);
    @(posedge core_clk);
    bus_grant_out <= 1'b0;
    #1;
    chk("slave_off", ext_master_access, 8'h00);
    chk("system_clock_out_toggle", system_clock_out, !c0);
  endtask
  task automatic s_instr();
    int n;
    @(posedge core_clk);
    reset_instr_exec <= 1'b1;
    @(posedge core_clk);
    reset_instr_exec <= 1'b0;
    #1;
    chk("instr_lines", lines, MASK_EXT);
    chk("instr_flag", instr_reset_flag, 8'h01);
    n = 0;
    while (ext_reset_drive !== 1'b0 && n < 60) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("instr_release", ext_reset_drive, 8'h00);
    chk("instr_clear", instr_reset_flag, 8'h00);
    repeat (30) @(posedge core_clk);
    #1;
    cfg_check(P0, 2'b10);
  endtask
  task automatic s_async(input bit halt, input logic [11:0] p, input logic [1:0] bk);
    @(posedge core_clk);
    drive_en <= 1'b1;
    pattern <= p;
    breakpoint_request <= bk;
    watchdog_timeout <= !halt;
    halt_fault <= halt;
    @(posedge core_clk);
    #1;
    chk("async_lines", lines, MASK_ALL);
    @(posedge core_clk);
    watchdog_timeout <= 1'b0;
    halt_fault <= 1'b0;
    finish_reset();
  endtask
  // A test source must wait for the open cycle; clock loss needs the monitor to end it.
  task automatic s_sync(input bit loss);
    int n;
    logic seen;
    @(posedge core_clk);
    bus_cycle_active <= 1'b1;
    drive_en <= 1'b1;
    ref_clock_loss <= loss;
    test_reset_req <= !loss;
    repeat (8) @(posedge core_clk);
    #1;
    chk("deferred", lines, MASK_NONE);
    if (!loss) begin
      @(posedge core_clk);
      bus_cycle_end <= 1'b1;
      // Held for a whole system clock period so that one tick is sure to see it.
      repeat (2) @(posedge core_clk);
      bus_cycle_end <= 1'b0;
      bus_cycle_active <= 1'b0;
    end
    n = 0;
    seen = 1'b0;
    while (master_reset !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      seen = seen | (bus_term_force === 1'b1);
      n++;
    end
    chk("monitor", seen, loss);
    chk("sync_lines", lines, loss ? MASK_ALL : MASK_TEST);
    @(posedge core_clk);
    ref_clock_loss <= 1'b0;
    test_reset_req <= 1'b0;
    bus_cycle_active <= 1'b0;
    finish_reset();
  endtask
  task automatic s_ext();
    int n;
    @(posedge core_clk);
    ext_req <= 1'b1;
    drive_en <= 1'b1;
    pattern <= P0;
    @(posedge core_clk);
    #1;
    chk("ext_sync", lines, MASK_NONE);
    n = 1;
    while (master_reset !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("ext_delay", 8'(n <= 5), 8'h01);
    chk("ext_lines", lines, MASK_ALL);
    @(posedge core_clk);
    ext_req <= 1'b0;
    finish_reset();
  endtask
  initial begin
    {watchdog_timeout, halt_fault, ref_clock_loss, test_reset_req, reset_instr_exec} = 5'h00;
    {bus_cycle_active, bus_cycle_end, bus_grant_out, ext_req, rst_b} = 5'h00;
    drive_en = 1'b1;
    pattern = P0;
    breakpoint_request = 2'b10;
    repeat (16) @(posedge core_clk);
    #1;
    chk("power_lines", lines, MASK_ALL);
    chk("power_flag", instr_reset_flag, 8'h00);
    @(posedge core_clk);
    rst_b <= 1'b1;
    finish_reset();
    s_slave();
    s_instr();
    s_async(1'b0, P1, 2'b11);
    s_async(1'b1, P0, 2'b01);
    breakpoint_request <= 2'b11;
    pattern <= P1;
    s_sync(1'b0);
    s_sync(1'b1);
    s_ext();
    give_verdict();
  end
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule // tb_reset_control_mode_select
